// ==== bench/bst_tester.sv ====
/*
 * Behavioural tester for the boundary-scan port: drives test clock,
 * mode select, serial in and test reset, and resolves the serial out line.
 * Assumes the bench calls its tasks hierarchically, one at a time.
 */
`default_nettype none

module bst_tester (
	// pins toward the port
	output logic      tck,
	output logic      trst_n,
	output logic      tms,
	output logic      tdi,
	// serial out from the port
	input  wire logic tdo,
	input  wire logic tdo_oe,
	// resolved line as the tester sees it
	output logic      tdo_line
);
	timeunit 1ns;
	timeprecision 1ps;

	logic last_q = 1'h0;

	// a released line shows the inverse of its last bit, so a stale copy cannot pass
	always @(tdo or tdo_oe) if (tdo_oe) last_q = tdo;
	assign tdo_line = tdo_oe ? tdo : ~last_q;

	// clock idles low between frames
	initial begin
		tck = 1'h0;
		trst_n = 1'h1;
		tms = 1'h1;
		tdi = 1'h0;
	end

	task automatic pin_reset();
		#1; // off time zero, so the falling reset edge is never missed
		trst_n = 1'h0;
		#60;
		trst_n = 1'h1;
	endtask

	task automatic step(input logic m, input logic d, output logic seen);
		#1;
		tms = m;
		tdi = d;
		#61.5;
		seen = tdo_line;
		tck = 1'h1;
		#62.5;
		tck = 1'h0;
	endtask
endmodule

`default_nettype wire

// ==== bench/tb_top.sv ====
/*
 * Self-checking bench for the boundary-scan controller: instruction and
 * data scans, every code, pad control, pause paths and both resets.
 * Assumes the tester model owns the test clock at a 125 ns period.
 */
`default_nettype none

module tb_top
	import bst_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clock = 1'h0;
	logic       arst_n, tck, trst_n, tms, tdi, tdo, tdo_oe, tdo_line;
	logic [3:0] core_out, core_in, pad_in, pad_out;
	logic       core_oe, pad_oe, scan_owns_pads;
	int         n_fail = 0;
	int         checks_done = 0;

	// paused instruction scan to bypass: mode select and serial in, edge 0 in bit 0
	localparam logic [12:0] PIR_MODE = 13'h0c93;
	localparam logic [12:0] PIR_DATA = 13'h0610;

	always #20 clock = ~clock;

	bst_tap uut (.clock(clock), .arst_n(arst_n), .test_clock_pin(tck),
		.test_reset_pin_n(trst_n), .test_mode_select(tms), .test_serial_in(tdi),
		.test_serial_out(tdo), .test_serial_out_oe(tdo_oe), .core_out(core_out),
		.core_oe(core_oe), .core_in(core_in), .pad_in(pad_in), .pad_out(pad_out),
		.pad_oe(pad_oe), .scan_owns_pads(scan_owns_pads));

	bst_tester tap (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo),
		.tdo_oe(tdo_oe), .tdo_line(tdo_line));

	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	// register length each code must put between serial in and out
	function automatic int exp_len(input bst_instr_t c);
		if (c == INSTR_EXTEST || c == INSTR_SAMPLE) return BSR_LEN;
		if (c == INSTR_IDCODE) return ID_LEN;
		return 1;
	endfunction

	// new random core and pad levels, held long enough to be captured
	task automatic set_core();
		@(posedge clock);
		core_out <= 4'($urandom);
		core_oe <= 1'($urandom);
		pad_in <= 4'($urandom);
		repeat (4) @(posedge clock);
	endtask

	// pad control lags by a sync chain, so wait a bounded time for it
	task automatic check_pads(input logic [5:0] exp, input logic [5:0] mask);
		int k;
		k = 0;
		while ((({scan_owns_pads, pad_oe, pad_out} & mask) !== exp) && k < 40) begin
			@(negedge clock);
			k++;
		end
		check({scan_owns_pads, pad_oe, pad_out} & mask, exp, "pad control");
		if (k >= 40) begin
			close_out();
		end
	endtask

	task automatic ir_scan(input bst_instr_t code);
		logic       s;
		logic [2:0] cap;
		tap.step(1'h1, 1'h0, s);
		tap.step(1'h1, 1'h0, s);
		tap.step(1'h0, 1'h0, s);
		tap.step(1'h0, 1'h0, s);
		for (int i = 0; i < IR_LEN; i++) begin
			tap.step(i == IR_LEN - 1, code[i], s);
			cap[i] = s;
		end
		tap.step(1'h1, 1'h0, s);
		tap.step(1'h0, 1'h0, s);
		check(64'(cap), 64'(IR_CAPTURE), "instruction capture");
	endtask

	task automatic dr_scan(input logic [63:0] din, input int n, input int pause_at,
			output logic [63:0] dout);
		logic s;
		dout = '0;
		tap.step(1'h1, 1'h0, s);
		tap.step(1'h0, 1'h0, s);
		tap.step(1'h0, 1'h0, s);
		for (int i = 0; i < n; i++) begin
			tap.step(i == n - 1 || i == pause_at, din[i], s);
			dout[i] = s;
			if (i == pause_at && i != n - 1) begin
				tap.step(1'h0, 1'h0, s);
				#2;
				check(64'(tdo_oe), 64'h0, "serial out released");
				tap.step(1'h0, 1'h0, s);
				tap.step(1'h1, 1'h0, s);
				tap.step(1'h0, 1'h0, s);
			end
		end
		tap.step(1'h1, 1'h0, s);
		tap.step(1'h0, 1'h0, s);
	endtask

	initial begin
		#2_000_000;
		check(64'h0, 64'h1, "run time limit");
		close_out();
	end

	initial begin
		logic [63:0] d, q;
		logic [8:0]  v;
		logic        s;
		int          n;
		arst_n = 1'h0;
		core_out = 4'h0;
		core_oe = 1'h0;
		pad_in = 4'h0;
		void'($urandom(6046));
		tap.pin_reset();
		repeat (4) @(posedge clock);
		arst_n <= 1'h1;
		set_core();
		// leave the reset state before the first scan
		tap.step(1'h0, 1'h0, s);
		// identification word after test reset, with a pause mid-scan
		dr_scan(64'h0, ID_LEN, 12, q);
		check(64'(q[31:0]), 64'(ID_WORD), "id after reset");
		// every code selects a register of the right length
		for (int c = 0; c < 8; c++) begin
			n = exp_len(bst_instr_t'(c));
			d = {$urandom, $urandom};
			ir_scan(bst_instr_t'(c));
			dr_scan(d, n + 16, -1, q);
			check((q >> n) & 64'h0000_ffff, d & 64'h0000_ffff, "register length");
		end
		check(64'(q[0]), 64'h0, "bypass capture");
		// sample and preload, then drive the pads from the boundary latch
		set_core();
		ir_scan(INSTR_SAMPLE);
		v = 9'($urandom);
		dr_scan(64'(v), BSR_LEN, -1, q);
		check(64'(q[8:0]), 64'({core_oe, core_out, pad_in}), "boundary capture");
		check_pads({1'h0, core_oe, core_out}, 6'h3f);
		ir_scan(INSTR_EXTEST);
		check_pads({1'h1, v[8], v[7:4]}, 6'h3f);
		v = ~v;
		dr_scan(64'(v), BSR_LEN, -1, q);
		check_pads({1'h1, v[8], v[7:4]}, 6'h3f);
		ir_scan(INSTR_CLAMP);
		dr_scan(d, 1, -1, q);
		check_pads({1'h1, v[8], v[7:4]}, 6'h3f);
		ir_scan(INSTR_HIGHZ);
		check_pads(6'h20, 6'h30);
		ir_scan(INSTR_BYPASS);
		check_pads({1'h0, core_oe, core_out}, 6'h3f);
		check(64'(core_in), 64'(pad_in), "core sees pads");
		// five high edges from inside a data shift reach reset
		tap.step(1'h1, 1'h0, s);
		tap.step(1'h0, 1'h0, s);
		tap.step(1'h0, 1'h0, s);
		repeat (5) tap.step(1'h1, 1'h0, s);
		tap.step(1'h0, 1'h0, s);
		dr_scan(64'h0, ID_LEN, -1, q);
		check(64'(q[31:0]), 64'(ID_WORD), "id after mode reset");
		// bypass code shifted in through pause-IR and exit2-IR, then a length check
		for (int i = 0; i < 13; i++) begin
			tap.step(PIR_MODE[i], PIR_DATA[i], s);
		end
		d = {$urandom, $urandom};
		dr_scan(d, 17, -1, q);
		check((q >> 1) & 64'h0000_ffff, d & 64'h0000_ffff, "paused instruction scan");
		// test reset in mid instruction shift
		ir_scan(INSTR_BYPASS);
		tap.step(1'h1, 1'h0, s);
		tap.step(1'h1, 1'h0, s);
		tap.step(1'h0, 1'h0, s);
		tap.step(1'h0, 1'h0, s);
		tap.step(1'h0, 1'h1, s);
		tap.pin_reset();
		#2;
		check(64'(tdo_oe), 64'h0, "serial out after reset");
		tap.step(1'h0, 1'h0, s);
		dr_scan(64'h0, ID_LEN, -1, q);
		check(64'(q[31:0]), 64'(ID_WORD), "id after pin reset");
		close_out();
	end
endmodule

`default_nettype wire

// ==== logic/bst_pkg.sv ====
/*
 * Constants and types for the boundary-scan test access port controller:
 * instruction codes, register lengths, boundary cell layout, the
 * identification word and the sixteen controller states.
 * Assumes it is compiled before any design file that imports it.
 */
`default_nettype none

package bst_pkg;

	// instruction register
	localparam int IR_LEN = 3;
	typedef logic [IR_LEN-1:0] bst_instr_t;
	localparam bst_instr_t INSTR_EXTEST  = 3'h0;
	localparam bst_instr_t INSTR_IDCODE  = 3'h1;
	localparam bst_instr_t INSTR_SAMPLE  = 3'h2;
	localparam bst_instr_t INSTR_CLAMP   = 3'h3;
	localparam bst_instr_t INSTR_HIGHZ   = 3'h4;
	localparam bst_instr_t INSTR_BYPASS  = 3'h7;
	localparam bst_instr_t IR_CAPTURE    = 3'h1;

	// boundary register layout: inputs, output data, one output enable
	localparam int N_IN       = 4;
	localparam int N_OUT      = 4;
	localparam int BSR_LEN    = N_IN + N_OUT + 1;
	localparam int BSR_IN_LSB = 0;
	localparam int BSR_OUT_LSB = N_IN;
	localparam int BSR_OE_POS = N_IN + N_OUT;

	// identification word layout; all code values are arbitrary
	localparam int ID_LEN        = 32;
	localparam logic [3:0]  ID_REVISION = 4'h0;
	localparam logic [15:0] ID_PART     = 16'h00a5;
	localparam logic [10:0] ID_MAKER    = 11'h02a;
	localparam logic [31:0] ID_WORD     = {ID_REVISION, ID_PART, ID_MAKER, 1'b1};

	// reset values
	localparam logic              BYPASS_RESET = 1'b0;
	localparam logic [BSR_LEN-1:0] BSR_RESET   = 9'h000;

	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE,
		ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR,
		ST_UPD_DR,
		ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR,
		ST_UPD_IR
	} bst_state_t;

endpackage

`default_nettype wire

// ==== logic/bst_tap.sv ====
/*
 * Boundary-scan test access port controller: sixteen-state controller,
 * 3-bit instruction register, bypass, boundary and identification
 * registers, serial output, and boundary cells on four inputs, four
 * outputs and one shared output enable.
 * Assumes the tester owns the test clock; the core runs on clock.
 * Pad control crosses into the clock domain through two flops; it is
 * quasi-static, and a word is used only once two samples of it agree.
 */
`default_nettype none

//
// Behaviour
// R01 - controller moves only on rising test clock, steered by mode select
// R02 - test reset release leaves controller in reset state with identification instruction
// R03 - five rising edges with mode select high reach the reset state
// R04 - in reset state the pads run purely functionally
// R05 - run-test-idle keeps instruction and data registers unchanged
// R06 - select-DR holds registers; low goes capture-DR, high goes select-IR
// R07 - capture-DR loads selected register if allowed; low shift, high exit1
// R08 - shift-DR moves selected register one bit per edge; others hold
// R09 - exit1-DR: high goes update-DR, low goes pause-DR
// R10 - pause-DR halts shifting; low stays, high goes exit2-DR
// R11 - exit2-DR: high goes update-DR, low returns to shift-DR
// R12 - update-DR falling edge copies shift path into output latches
// R13 - from either update state: low goes idle, high goes select-DR
// R14 - select-IR holds registers; low goes capture-IR, high goes reset
// R15 - capture-IR loads 001; high goes exit1-IR, low goes shift-IR
// R16 - shift-IR shifts instruction stage; low stays, high goes exit1-IR
// R17 - exit1-IR: low goes pause-IR, high goes update-IR
// R18 - pause-IR halts shifting; low stays, high goes exit2-IR
// R19 - exit2-IR: high goes update-IR, low returns to shift-IR
// R20 - update-IR falling edge makes shifted instruction the active one
// R21 - supports sample, bypass, extest, highz, clamp and identification
// R22 - port is test clock, serial in, serial out, mode select, reset
// R23 - instruction register is three bits: shift stage plus parallel latch
// R24 - decode 000 extest, 001 id, 010 sample, 011 clamp, 100 highz, others bypass
// R25 - bypass connects serial in to out through one flop
// R26 - identification word loaded in capture-DR and shifted out in shift-DR
// R27 - run-test-idle: low stays, high goes select-DR
// R28 - serial out changes on falling edge, driven only in shift states
// R29 - low test reset forces reset state asynchronously until released
module bst_tap
	import bst_pkg::*;
(
	// core clock domain
	input  wire logic             clock,
	input  wire logic             arst_n,
	// R22 test access port
	input  wire logic             test_clock_pin,
	input  wire logic             test_reset_pin_n,
	input  wire logic             test_mode_select,
	input  wire logic             test_serial_in,
	output logic                  test_serial_out,
	output logic                  test_serial_out_oe,
	// core side of the boundary cells
	input  wire logic [N_OUT-1:0] core_out,
	input  wire logic             core_oe,
	output logic      [N_IN-1:0]  core_in,
	// pad side of the boundary cells
	input  wire logic [N_IN-1:0]  pad_in,
	output logic      [N_OUT-1:0] pad_out,
	output logic                  pad_oe,
	// status in the core domain
	output logic                  scan_owns_pads
);

	localparam int CTL_W = N_OUT + 3;

	bst_state_t           state_reg;
	bst_state_t           state_next;
	bst_instr_t           ir_shift_reg;
	bst_instr_t           ir_active_reg;
	logic                 bypass_reg;
	logic [ID_LEN-1:0]    id_shift_reg;
	logic [BSR_LEN-1:0]   bsr_shift_reg;
	logic [BSR_LEN-1:0]   bsr_upd_reg;
	logic [N_IN-1:0]      tpad_meta_reg;
	logic [N_IN-1:0]      tpad_sync_reg;
	logic [N_OUT:0]       tcore_meta_reg;
	logic [N_OUT:0]       tcore_sync_reg;
	logic                 tdo_reg;
	logic                 tdo_oe_reg;
	logic                 sel_bsr;
	logic                 sel_id;
	logic                 bsr_drives;
	logic                 bsr_hiz;
	logic                 tdo_next;
	logic [CTL_W-1:0]     ctl_tck;
	logic [CTL_W-1:0]     ctl_meta_reg;
	logic [CTL_W-1:0]     ctl_sync_reg;
	logic [CTL_W-1:0]     ctl_last_reg;
	logic [CTL_W-1:0]     ctl_ok_reg;
	logic [N_IN-1:0]      cpad_meta_reg;
	logic [N_IN-1:0]      cpad_sync_reg;
	logic [N_OUT-1:0]     pad_out_reg;
	logic                 pad_oe_reg;

	// R29 test reset
	// the test reset pin is the asynchronous reset of the whole test domain
	wire tap_rst_n = test_reset_pin_n;

	// R24 instruction decode
	// unlisted codes fall back to the bypass stage
	always_comb begin
		sel_bsr    = (ir_active_reg == INSTR_EXTEST) || (ir_active_reg == INSTR_SAMPLE);
		sel_id     = (ir_active_reg == INSTR_IDCODE);
		bsr_drives = (ir_active_reg == INSTR_EXTEST) || (ir_active_reg == INSTR_CLAMP);
		bsr_hiz    = (ir_active_reg == INSTR_HIGHZ);
	end

	// R01 next state
	// standard sixteen-state graph, decided by mode select at the rising edge
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			// R03 reset hold
			ST_RESET:    state_next = test_mode_select ? ST_RESET : ST_IDLE;
			// R27 idle exits
			ST_IDLE:     state_next = test_mode_select ? ST_SEL_DR : ST_IDLE;
			// R06 select-DR exits
			ST_SEL_DR:   state_next = test_mode_select ? ST_SEL_IR : ST_CAP_DR;
			// R07 capture-DR exits
			ST_CAP_DR:   state_next = test_mode_select ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: state_next = test_mode_select ? ST_EXIT1_DR : ST_SHIFT_DR;
			// R09 exit1-DR exits
			ST_EXIT1_DR: state_next = test_mode_select ? ST_UPD_DR : ST_PAUSE_DR;
			// R10 pause-DR exits
			ST_PAUSE_DR: state_next = test_mode_select ? ST_EXIT2_DR : ST_PAUSE_DR;
			// R11 exit2-DR exits
			ST_EXIT2_DR: state_next = test_mode_select ? ST_UPD_DR : ST_SHIFT_DR;
			// R13 update exits
			ST_UPD_DR,
			ST_UPD_IR:   state_next = test_mode_select ? ST_SEL_DR : ST_IDLE;
			// R14 select-IR exits
			ST_SEL_IR:   state_next = test_mode_select ? ST_RESET : ST_CAP_IR;
			// R15 capture-IR exits
			ST_CAP_IR:   state_next = test_mode_select ? ST_EXIT1_IR : ST_SHIFT_IR;
			// R16 shift-IR exits
			ST_SHIFT_IR: state_next = test_mode_select ? ST_EXIT1_IR : ST_SHIFT_IR;
			// R17 exit1-IR exits
			ST_EXIT1_IR: state_next = test_mode_select ? ST_UPD_IR : ST_PAUSE_IR;
			// R18 pause-IR exits
			ST_PAUSE_IR: state_next = test_mode_select ? ST_EXIT2_IR : ST_PAUSE_IR;
			// R19 exit2-IR exits
			ST_EXIT2_IR: state_next = test_mode_select ? ST_UPD_IR : ST_SHIFT_IR;
			default:     state_next = ST_RESET;
		endcase
	end

	// R01 state register
	// R29 forced reset state while the reset pin is low
	always_ff @(posedge test_clock_pin or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			state_reg <= ST_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// R23 three-bit shift stage
	// R15 instruction capture
	// R16 instruction shift, lsb leaves first
	always_ff @(posedge test_clock_pin or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			ir_shift_reg <= IR_CAPTURE;
		end else if (state_reg == ST_CAP_IR) begin
			ir_shift_reg <= IR_CAPTURE;
		end else if (state_reg == ST_SHIFT_IR) begin
			ir_shift_reg <= {test_serial_in, ir_shift_reg[IR_LEN-1:1]};
		end
	end

	// R20 instruction update
	// R02 identification instruction in reset state
	// falling edge keeps the active code stable across the rising edge
	always_ff @(negedge test_clock_pin or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			ir_active_reg <= INSTR_IDCODE;
		end else if (state_reg == ST_RESET) begin
			ir_active_reg <= INSTR_IDCODE;
		end else if (state_reg == ST_UPD_IR) begin
			ir_active_reg <= ir_shift_reg;
		end
	end

	// R25 bypass stage
	// captures zero so a chain length check sees a known bit
	always_ff @(posedge test_clock_pin or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			bypass_reg <= BYPASS_RESET;
		end else if (!sel_bsr && !sel_id) begin
			if (state_reg == ST_CAP_DR) begin
				bypass_reg <= BYPASS_RESET;
			end else if (state_reg == ST_SHIFT_DR) begin
				bypass_reg <= test_serial_in;
			end
		end
	end

	// R26 identification register
	always_ff @(posedge test_clock_pin or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			id_shift_reg <= ID_WORD;
		end else if (sel_id) begin
			if (state_reg == ST_CAP_DR) begin
				id_shift_reg <= ID_WORD;
			end else if (state_reg == ST_SHIFT_DR) begin
				id_shift_reg <= {test_serial_in, id_shift_reg[ID_LEN-1:1]};
			end
		end
	end

	// pad inputs and core outputs come from other domains: two flops first
	always_ff @(posedge test_clock_pin or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			tpad_meta_reg  <= '0;
			tpad_sync_reg  <= '0;
			tcore_meta_reg <= '0;
			tcore_sync_reg <= '0;
		end else begin
			tpad_meta_reg  <= pad_in;
			tpad_sync_reg  <= tpad_meta_reg;
			tcore_meta_reg <= {core_oe, core_out};
			tcore_sync_reg <= tcore_meta_reg;
		end
	end

	// R07 boundary capture
	// R08 boundary shift, other registers hold
	// R05 idle and pause states fall through and keep contents
	always_ff @(posedge test_clock_pin or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			bsr_shift_reg <= BSR_RESET;
		end else if (sel_bsr) begin
			if (state_reg == ST_CAP_DR) begin
				bsr_shift_reg <= {tcore_sync_reg, tpad_sync_reg};
			end else if (state_reg == ST_SHIFT_DR) begin
				bsr_shift_reg <= {test_serial_in, bsr_shift_reg[BSR_LEN-1:1]};
			end
		end
	end

	// R12 boundary update latch
	// later shifting leaves the driven pattern untouched
	always_ff @(negedge test_clock_pin or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			bsr_upd_reg <= BSR_RESET;
		end else if (state_reg == ST_UPD_DR && sel_bsr) begin
			bsr_upd_reg <= bsr_shift_reg;
		end
	end

	// R28 serial output select
	always_comb begin
		if (state_reg == ST_SHIFT_IR) begin
			tdo_next = ir_shift_reg[0];
		end else if (sel_bsr) begin
			tdo_next = bsr_shift_reg[0];
		end else if (sel_id) begin
			tdo_next = id_shift_reg[0];
		end else begin
			tdo_next = bypass_reg;
		end
	end

	// R28 serial output on falling edge, enabled only while shifting
	always_ff @(negedge test_clock_pin or negedge tap_rst_n) begin
		if (!tap_rst_n) begin
			tdo_reg    <= 1'b0;
			tdo_oe_reg <= 1'b0;
		end else begin
			tdo_reg    <= tdo_next;
			tdo_oe_reg <= (state_reg == ST_SHIFT_DR) || (state_reg == ST_SHIFT_IR);
		end
	end

	assign test_serial_out    = tdo_reg;
	assign test_serial_out_oe = tdo_oe_reg;

	// R21 pad control word handed to the core domain
	assign ctl_tck = {bsr_drives, bsr_hiz,
		bsr_upd_reg[BSR_OE_POS], bsr_upd_reg[BSR_OUT_LSB +: N_OUT]};

	// core domain: control word and pad inputs each pass two flops
	// word bits may settle in different cycles, so it is taken only when two samples agree
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ctl_meta_reg  <= '0;
			ctl_sync_reg  <= '0;
			ctl_last_reg  <= '0;
			ctl_ok_reg    <= '0;
			cpad_meta_reg <= '0;
			cpad_sync_reg <= '0;
		end else begin
			ctl_meta_reg  <= ctl_tck;
			ctl_sync_reg  <= ctl_meta_reg;
			ctl_last_reg  <= ctl_sync_reg;
			if (ctl_sync_reg == ctl_last_reg) begin
				ctl_ok_reg <= ctl_sync_reg;
			end
			cpad_meta_reg <= pad_in;
			cpad_sync_reg <= cpad_meta_reg;
		end
	end

	// R04 pads functional unless extest, clamp or highz is active
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pad_out_reg <= '0;
			pad_oe_reg  <= 1'b0;
		end else if (ctl_ok_reg[CTL_W-2]) begin
			pad_out_reg <= core_out;
			pad_oe_reg  <= 1'b0;
		end else if (ctl_ok_reg[CTL_W-1]) begin
			pad_out_reg <= ctl_ok_reg[N_OUT-1:0];
			pad_oe_reg  <= ctl_ok_reg[N_OUT];
		end else begin
			pad_out_reg <= core_out;
			pad_oe_reg  <= core_oe;
		end
	end

	assign pad_out        = pad_out_reg;
	assign pad_oe         = pad_oe_reg;
	assign core_in        = cpad_sync_reg;
	assign scan_owns_pads = ctl_ok_reg[CTL_W-1] | ctl_ok_reg[CTL_W-2];

	five_ones_reset_a: assert property ( // R03
		@(posedge test_clock_pin) disable iff (!tap_rst_n)
		test_mode_select [*5] |=> state_reg == ST_RESET)
		else $error("five mode-select-high edges did not reach reset state");

	reset_pads_free_a: assert property ( // R04
		@(posedge test_clock_pin) disable iff (!tap_rst_n)
		state_reg == ST_RESET |-> !bsr_drives && !bsr_hiz && ir_active_reg == INSTR_IDCODE)
		else $error("reset state does not leave pads functional");

	idle_holds_regs_a: assert property ( // R05
		@(posedge test_clock_pin) disable iff (!tap_rst_n)
		state_reg == ST_IDLE && !test_mode_select |=>
		state_reg == ST_IDLE && $stable(ir_shift_reg) && $stable(bsr_shift_reg)
		&& $stable(id_shift_reg))
		else $error("registers changed in run-test-idle");

	sel_dr_branch_a: assert property ( // R06
		@(posedge test_clock_pin) disable iff (!tap_rst_n)
		state_reg == ST_SEL_DR |=>
		state_reg == ($past(test_mode_select) ? ST_SEL_IR : ST_CAP_DR))
		else $error("wrong exit from select-DR");

	id_capture_a: assert property ( // R26
		@(posedge test_clock_pin) disable iff (!tap_rst_n)
		state_reg == ST_CAP_DR && sel_id |=> id_shift_reg == ID_WORD)
		else $error("identification word not captured");

	bsr_shift_step_a: assert property ( // R08
		@(posedge test_clock_pin) disable iff (!tap_rst_n)
		state_reg == ST_SHIFT_DR && sel_bsr |=>
		bsr_shift_reg == {$past(test_serial_in), $past(bsr_shift_reg[BSR_LEN-1:1])}
		&& $stable(ir_shift_reg))
		else $error("boundary register did not shift one place");

	bypass_path_a: assert property ( // R25
		@(posedge test_clock_pin) disable iff (!tap_rst_n)
		state_reg == ST_SHIFT_DR && !sel_bsr && !sel_id |=>
		bypass_reg == $past(test_serial_in))
		else $error("bypass stage did not take serial input");

	pause_dr_hold_a: assert property ( // R10
		@(posedge test_clock_pin) disable iff (!tap_rst_n)
		state_reg == ST_PAUSE_DR && !test_mode_select |=>
		state_reg == ST_PAUSE_DR && $stable(bsr_shift_reg) && $stable(id_shift_reg))
		else $error("pause-DR did not hold");

	ir_capture_a: assert property ( // R15
		@(posedge test_clock_pin) disable iff (!tap_rst_n)
		state_reg == ST_CAP_IR |=> ir_shift_reg == IR_CAPTURE
		&& state_reg == ($past(test_mode_select) ? ST_EXIT1_IR : ST_SHIFT_IR))
		else $error("capture-IR did not load the fixed pattern");

	ir_update_a: assert property ( // R20
		@(posedge test_clock_pin) disable iff (!tap_rst_n)
		state_reg == ST_UPD_IR |-> ir_active_reg == ir_shift_reg)
		else $error("update-IR did not make the shifted code active");

	exit2_ir_branch_a: assert property ( // R19
		@(posedge test_clock_pin) disable iff (!tap_rst_n)
		state_reg == ST_EXIT2_IR ##1 state_reg == ST_SHIFT_IR |-> !$past(test_mode_select))
		else $error("exit2-IR returned to shift with mode select high");

	tdo_enable_a: assert property ( // R28
		@(posedge test_clock_pin) disable iff (!tap_rst_n)
		test_serial_out_oe == (state_reg == ST_SHIFT_DR || state_reg == ST_SHIFT_IR))
		else $error("serial output enabled outside shift states");

endmodule

`default_nettype wire
